// ===== core/charge_param_defs.svh
// Constants for the charger configuration register bank and its serial port.
// Assumes inclusion by bare name from files under core/.
`ifndef CHARGE_PARAM_DEFS_SVH
`define CHARGE_PARAM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets on the two-wire link
// ----------------------------------------------------------------------------
`define CPR_OFS_WDT_CTRL 8'h01
`define CPR_OFS_PRECHG_TERM 8'h03
`define CPR_OFS_VOLT 8'h04
`define CPR_OFS_TIMER 8'h05

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CPR_RST_PRECHG_TERM 8'h11
`define CPR_RST_VOLT 8'hB2
`define CPR_RST_TIMER 8'h9A
`define CPR_RST_READ 8'h00

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CPR_PRECHG_MSB 7
`define CPR_PRECHG_LSB 4
`define CPR_TERM_MSB 3
`define CPR_TERM_LSB 0
`define CPR_CHARGE_VOLTAGE_LIMIT_MSB 7
`define CPR_CHARGE_VOLTAGE_LIMIT_LSB 2
`define CPR_LOWV_BIT 1
`define CPR_RECHG_BIT 0
`define CPR_EN_TERM_BIT 7
`define CPR_TERM_IND_BIT 6
`define CPR_WDOG_MSB 5
`define CPR_WDOG_LSB 4
`define CPR_EN_TIMER_BIT 3
`define CPR_CHG_TMR_MSB 2
`define CPR_CHG_TMR_LSB 1
`define CPR_WDT_RESTART_BIT 6

// ----------------------------------------------------------------------------
// Serial port constants
// ----------------------------------------------------------------------------
// Arbitrary neutral slave address
`define CPR_DEF_DEV_ADDR 7'h2A
`define CPR_BITS_PER_BYTE 4'h8

`endif

// ===== core/charge_param_pkg.sv
// Types shared by the configuration register bank and its serial front end.
// Assumes nothing of its surroundings.
package charge_param_pkg;

   // -------------------------------------------------------------------------
   // Serial slave states, Gray coded along the write path and the read data loop
   // -------------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_ADDR      = 4'h1,
      ST_ADDR_ACK  = 4'h3,
      ST_REG       = 4'h2,
      ST_REG_ACK   = 4'h6,
      ST_WDATA     = 4'h7,
      ST_WDATA_ACK = 4'h5,
      ST_RDATA     = 4'h4,
      ST_RDATA_ACK = 4'hC
   } link_state_e;

   // -------------------------------------------------------------------------
   // Front end state
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic scl_meta;
      logic scl_sync;
      logic scl_last;
      logic sda_meta;
      logic sda_sync;
      logic sda_last;
      link_state_e st;
      logic [3:0] cnt;
      logic [7:0] shreg;
      logic [7:0] ptr;
      logic rw;
      logic sda_pull;
   } link_state_s;

   // -------------------------------------------------------------------------
   // Register bank state
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [7:0] prechg_term;
      logic [7:0] volt;
      logic [7:0] timer;
      logic wdt_restart;
      logic [7:0] rd_data;
   } bank_state_s;

endpackage

// ===== core/charge_param_bank.sv
// Three charger configuration registers plus the self-clearing watchdog
// restart bit. Assumes one clock and writes from the serial front end.
`timescale 1ns/1ps
`default_nettype none
`include "charge_param_defs.svh"

module charge_param_bank
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic wr_en_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wr_data_i,
   output logic [7:0] rd_data_o,
   output logic [7:0] prechg_term_o,
   output logic [7:0] volt_o,
   output logic [7:0] timer_o,
   output logic wdt_restart_o
);

   // Current and next state
   charge_param_pkg::bank_state_s q_ff;
   charge_param_pkg::bank_state_s nxt_q;

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb
   begin
      nxt_q = q_ff;
      // Restart request lives one cycle only [R13]
      nxt_q.wdt_restart = 1'b0;
      if (wr_en_i)
      begin
         case (addr_i)
            // Whole byte kept so readback is exact [R14]
            `CPR_OFS_PRECHG_TERM: nxt_q.prechg_term = wr_data_i; // [R01]
            `CPR_OFS_VOLT: nxt_q.volt = wr_data_i; // [R03]
            // Reserved bit stored as written; host keeps it zero [R11]
            `CPR_OFS_TIMER: nxt_q.timer = wr_data_i; // [R07]
            // Only the restart bit of this register is served [R13]
            `CPR_OFS_WDT_CTRL: nxt_q.wdt_restart = wr_data_i[`CPR_WDT_RESTART_BIT];
            // Unmapped writes dropped
            default: nxt_q.wdt_restart = 1'b0;
         endcase
      end
      // Read data registered from current contents [R14]
      case (addr_i)
         `CPR_OFS_PRECHG_TERM: nxt_q.rd_data = q_ff.prechg_term;
         `CPR_OFS_VOLT: nxt_q.rd_data = q_ff.volt;
         `CPR_OFS_TIMER: nxt_q.rd_data = q_ff.timer;
         `CPR_OFS_WDT_CTRL: nxt_q.rd_data = {1'b0, q_ff.wdt_restart, 6'h00};
         // Unmapped reads give zero
         default: nxt_q.rd_data = `CPR_RST_READ;
      endcase
   end

   // -------------------------------------------------------------------------
   // State register with documented defaults
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         q_ff.prechg_term <= `CPR_RST_PRECHG_TERM; // [R02]
         q_ff.volt <= `CPR_RST_VOLT; // [R04] [R05] [R06]
         q_ff.timer <= `CPR_RST_TIMER; // [R12] [R08] [R09] [R10]
         q_ff.wdt_restart <= 1'b0;
         q_ff.rd_data <= `CPR_RST_READ;
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

   // Outputs straight from flip-flops
   assign rd_data_o = q_ff.rd_data;
   assign prechg_term_o = q_ff.prechg_term;
   assign volt_o = q_ff.volt;
   assign timer_o = q_ff.timer;
   assign wdt_restart_o = q_ff.wdt_restart;

endmodule // charge_param_bank

`default_nettype wire

// ===== core/charge_param_config_regs.sv
// Charger configuration registers reached over a two-wire serial slave.
// Assumes SCL and SDA arrive asynchronously and that an external open-drain
// pad resolves SDA from sda_o and sda_oe_n_o; SCL is never stretched.
`timescale 1ns/1ps
`default_nettype none
`include "charge_param_defs.svh"

// Summary of operation
// (R01) Current fields: 128 mA offset, 128 mA steps
// (R02) Current register resets to 0x11
// (R03) Voltage code: 3.504 V plus 16 mV steps
// (R04) Voltage register resets to 0xB2
// (R05) Bit 1 picks 2.8 or 3.0 V
// (R06) Bit 0 picks 100 or 300 mV
// (R07) Bit 7 enables termination, default on
// (R08) Bit 6 selects termination indication style
// (R09) Bits 5:4 select watchdog period
// (R10) Safety timer enable and duration fields
// (R11) Host writes zero to reserved bit
// (R12) Timer register resets to 0x9A
// (R13) Watchdog restart bit self-clears after use
// (R14) Every bit reads back last write; register 0x01 reads back zero except during the one-cycle restart pulse
module charge_param_config_regs
#(
   parameter logic [6:0] DEV_ADDR = `CPR_DEF_DEV_ADDR
)
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n_o,
   output logic [3:0] precharge_current_limit_o,
   output logic [3:0] termination_current_limit_o,
   output logic [5:0] charge_voltage_limit_o,
   output logic precharge_to_fast_threshold_o,
   output logic recharge_threshold_o,
   output logic termination_enable_o,
   output logic termination_indicator_select_o,
   output logic [1:0] watchdog_period_select_o,
   output logic safety_timer_enable_o,
   output logic [1:0] fast_charge_timer_select_o,
   output logic watchdog_restart_o
);

   // -------------------------------------------------------------------------
   // Elaboration checks
   // -------------------------------------------------------------------------
   // Addresses 0000xxx and 1111xxx are reserved on the bus
   generate
      if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hF)
      begin : g_bad_addr
         $error("DEV_ADDR falls in a reserved address group");
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------------
   charge_param_pkg::link_state_s q_ff; // Current state
   charge_param_pkg::link_state_s nxt_q; // Next state
   logic scl_rise; // SCL rising edge seen
   logic scl_fall; // SCL falling edge seen
   logic bus_start; // Start condition
   logic bus_stop; // Stop condition
   logic wr_en; // Bank write strobe
   logic [7:0] rd_data; // Bank read data, registered
   logic [7:0] prechg_term; // Current limits register
   logic [7:0] volt; // Voltage register
   logic [7:0] timer; // Timer control register

   // -------------------------------------------------------------------------
   // Bus condition detection on synchronised pins
   // -------------------------------------------------------------------------
   // Only the second and third stages are looked at
   always_comb
   begin
      scl_rise = q_ff.scl_sync & ~q_ff.scl_last;
      scl_fall = ~q_ff.scl_sync & q_ff.scl_last;
      bus_start = q_ff.scl_sync & q_ff.scl_last & q_ff.sda_last & ~q_ff.sda_sync;
      bus_stop = q_ff.scl_sync & q_ff.scl_last & ~q_ff.sda_last & q_ff.sda_sync;
   end

   // -------------------------------------------------------------------------
   // Slave sequencing
   // -------------------------------------------------------------------------
   always_comb
   begin
      nxt_q = q_ff;
      wr_en = 1'b0;
      // Two-stage synchronisers, then an edge-history stage
      nxt_q.scl_meta = scl_i;
      nxt_q.scl_sync = q_ff.scl_meta;
      nxt_q.scl_last = q_ff.scl_sync;
      nxt_q.sda_meta = sda_i;
      nxt_q.sda_sync = q_ff.sda_meta;
      nxt_q.sda_last = q_ff.sda_sync;
      if (bus_start)
      begin
         // Start or repeated start; pointer kept for reads
         nxt_q.st = charge_param_pkg::ST_ADDR;
         nxt_q.cnt = 4'h0;
         nxt_q.sda_pull = 1'b0;
      end
      else if (bus_stop)
      begin
         // Stop ends any transfer
         nxt_q.st = charge_param_pkg::ST_IDLE;
         nxt_q.sda_pull = 1'b0;
      end
      else
      begin
         // Receiving states shift in on rising SCL, MSB first
         if (scl_rise && (q_ff.st == charge_param_pkg::ST_ADDR ||
            q_ff.st == charge_param_pkg::ST_REG || q_ff.st == charge_param_pkg::ST_WDATA))
         begin
            nxt_q.shreg = {q_ff.shreg[6:0], q_ff.sda_sync};
            nxt_q.cnt = q_ff.cnt + 4'h1;
         end
         case (q_ff.st)
            // Waiting for a start
            charge_param_pkg::ST_IDLE:
               nxt_q.sda_pull = 1'b0;
            // Address byte done: answer only our own address
            charge_param_pkg::ST_ADDR:
               if (scl_fall && q_ff.cnt == `CPR_BITS_PER_BYTE)
               begin
                  nxt_q.cnt = 4'h0;
                  if (q_ff.shreg[7:1] == DEV_ADDR)
                  begin
                     nxt_q.st = charge_param_pkg::ST_ADDR_ACK;
                     nxt_q.rw = q_ff.shreg[0];
                     nxt_q.sda_pull = 1'b1;
                  end
                  else
                  begin
                     // Not us: stay off the bus until next start
                     nxt_q.st = charge_param_pkg::ST_IDLE;
                  end
               end
            // Address acknowledge clock
            charge_param_pkg::ST_ADDR_ACK:
               if (scl_fall && q_ff.rw)
               begin
                  // First read byte; first bit out now
                  nxt_q.st = charge_param_pkg::ST_RDATA;
                  nxt_q.shreg = rd_data; // [R14]
                  nxt_q.sda_pull = ~rd_data[7];
               end
               else if (scl_fall)
               begin
                  nxt_q.st = charge_param_pkg::ST_REG;
                  nxt_q.sda_pull = 1'b0;
               end
            // Register pointer byte done
            charge_param_pkg::ST_REG:
               if (scl_fall && q_ff.cnt == `CPR_BITS_PER_BYTE)
               begin
                  nxt_q.ptr = q_ff.shreg;
                  nxt_q.cnt = 4'h0;
                  nxt_q.st = charge_param_pkg::ST_REG_ACK;
                  nxt_q.sda_pull = 1'b1;
               end
            // Pointer acknowledge clock
            charge_param_pkg::ST_REG_ACK:
               if (scl_fall)
               begin
                  nxt_q.st = charge_param_pkg::ST_WDATA;
                  nxt_q.sda_pull = 1'b0;
               end
            // Write data byte done
            charge_param_pkg::ST_WDATA:
               if (scl_fall && q_ff.cnt == `CPR_BITS_PER_BYTE)
               begin
                  // Byte lands in the bank as the acknowledge starts
                  wr_en = 1'b1; // [R14]
                  nxt_q.cnt = 4'h0;
                  nxt_q.st = charge_param_pkg::ST_WDATA_ACK;
                  nxt_q.sda_pull = 1'b1;
               end
            // Write acknowledge clock; pointer steps for bursts
            charge_param_pkg::ST_WDATA_ACK:
               if (scl_fall)
               begin
                  nxt_q.st = charge_param_pkg::ST_WDATA;
                  nxt_q.ptr = q_ff.ptr + 8'h01;
                  nxt_q.sda_pull = 1'b0;
               end
            // Read data shifting out on falling edges
            charge_param_pkg::ST_RDATA:
               if (scl_fall && q_ff.cnt == 4'h7)
               begin
                  // Release for master acknowledge
                  nxt_q.st = charge_param_pkg::ST_RDATA_ACK;
                  nxt_q.sda_pull = 1'b0;
                  nxt_q.ptr = q_ff.ptr + 8'h01;
                  nxt_q.cnt = 4'h0;
               end
               else if (scl_fall)
               begin
                  nxt_q.shreg = {q_ff.shreg[6:0], 1'b0};
                  nxt_q.sda_pull = ~q_ff.shreg[6];
                  nxt_q.cnt = q_ff.cnt + 4'h1;
               end
            // Master acknowledge; a not-acknowledge ends the read
            charge_param_pkg::ST_RDATA_ACK:
               if (scl_rise)
                  nxt_q.cnt = {3'h0, q_ff.sda_sync};
               else if (scl_fall && q_ff.cnt[0] == 1'b0)
               begin
                  // Bank data has had a full SCL period to settle
                  nxt_q.st = charge_param_pkg::ST_RDATA;
                  nxt_q.shreg = rd_data;
                  nxt_q.sda_pull = ~rd_data[7];
                  nxt_q.cnt = 4'h0;
               end
               else if (scl_fall)
                  nxt_q.st = charge_param_pkg::ST_IDLE;
            // Illegal codes recover to idle
            default:
            begin
               nxt_q.st = charge_param_pkg::ST_IDLE;
               nxt_q.sda_pull = 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // State register; idle bus levels at reset
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         q_ff <= '{scl_meta: 1'b1, scl_sync: 1'b1, scl_last: 1'b1, sda_meta: 1'b1,
            sda_sync: 1'b1, sda_last: 1'b1, st: charge_param_pkg::ST_IDLE, default: '0};
      end
      else
      begin
         q_ff <= nxt_q;
      end
   end

   // -------------------------------------------------------------------------
   // Register bank
   // -------------------------------------------------------------------------
   charge_param_bank u_bank
   (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .wr_en_i(wr_en),
      .addr_i(q_ff.ptr),
      .wr_data_i(q_ff.shreg),
      .rd_data_o(rd_data),
      .prechg_term_o(prechg_term),
      .volt_o(volt),
      .timer_o(timer),
      .wdt_restart_o(watchdog_restart_o)
   );

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   // Open drain: low level only, enable low while pulling
   assign sda_o = 1'b0;
   assign sda_oe_n_o = ~q_ff.sda_pull;
   // Field taps, all from bank flip-flops
   assign precharge_current_limit_o = prechg_term[`CPR_PRECHG_MSB:`CPR_PRECHG_LSB]; // [R01]
   assign termination_current_limit_o = prechg_term[`CPR_TERM_MSB:`CPR_TERM_LSB]; // [R01]
   assign charge_voltage_limit_o = volt[`CPR_CHARGE_VOLTAGE_LIMIT_MSB:`CPR_CHARGE_VOLTAGE_LIMIT_LSB]; // [R03]
   assign precharge_to_fast_threshold_o = volt[`CPR_LOWV_BIT]; // [R05]
   assign recharge_threshold_o = volt[`CPR_RECHG_BIT]; // [R06]
   assign termination_enable_o = timer[`CPR_EN_TERM_BIT]; // [R07]
   assign termination_indicator_select_o = timer[`CPR_TERM_IND_BIT]; // [R08]
   assign watchdog_period_select_o = timer[`CPR_WDOG_MSB:`CPR_WDOG_LSB]; // [R09]
   assign safety_timer_enable_o = timer[`CPR_EN_TIMER_BIT]; // [R10]
   assign fast_charge_timer_select_o = timer[`CPR_CHG_TMR_MSB:`CPR_CHG_TMR_LSB]; // [R10]

endmodule // charge_param_config_regs

`default_nettype wire

// ===== test/charge_param_config_regs_asserts.sv
// Port checks for the charger configuration registers.
// Assumes a bind onto the top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module charge_param_config_regs_asserts
(
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic scl_i,
   input wire logic sda_oe_n_o,
   input wire logic [3:0] precharge_current_limit_o,
   input wire logic [3:0] termination_current_limit_o,
   input wire logic [5:0] charge_voltage_limit_o,
   input wire logic precharge_to_fast_threshold_o,
   input wire logic recharge_threshold_o,
   input wire logic termination_enable_o,
   input wire logic termination_indicator_select_o,
   input wire logic [1:0] watchdog_period_select_o,
   input wire logic safety_timer_enable_o,
   input wire logic [1:0] fast_charge_timer_select_o,
   input wire logic watchdog_restart_o
);
   // ------------
   // Register views
   // ------------
   logic [7:0] cur_v;
   logic [7:0] volt_v;
   logic [6:0] tmr_v; // Reserved bit 0 has no port
   assign cur_v = {precharge_current_limit_o, termination_current_limit_o};
   assign volt_v = {charge_voltage_limit_o, precharge_to_fast_threshold_o,
      recharge_threshold_o};
   assign tmr_v = {termination_enable_o, termination_indicator_select_o,
      watchdog_period_select_o, safety_timer_enable_o, fast_charge_timer_select_o};
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   // ------------
   // Properties
   // ------------
   AST_RST_CUR: assert property ($rose(resetn_i) |-> cur_v == 8'h11)
      else $error("current register default wrong");
   AST_RST_VOLT: assert property ($rose(resetn_i) |-> volt_v == 8'hB2)
      else $error("voltage register default wrong");
   AST_RST_TMR: assert property ($rose(resetn_i) |-> tmr_v == 7'h4D)
      else $error("timer register default wrong");
   // Writes land only after a serial clock fall
   AST_FLD_LOW: assert property ($changed(cur_v) || $changed(volt_v) |-> !scl_i)
      else $error("field moved with serial clock high");
   AST_TMR_LOW: assert property ($changed(tmr_v) |-> !scl_i && !$past(scl_i, 2))
      else $error("timer field moved off a clock fall");
   // Acknowledge or zero bit holds at least 8 clocks
   AST_ACK_HOLD: assert property ($fell(sda_oe_n_o) |-> !sda_oe_n_o [*8])
      else $error("data line pull too short");
   AST_PULSE_ONE: assert property (watchdog_restart_o |=> !watchdog_restart_o)
      else $error("restart bit not self cleared");
   AST_PULSE_SCL: assert property ($rose(watchdog_restart_o) |-> !scl_i)
      else $error("restart outside a write");
   cover property (watchdog_restart_o);
   cover property ($fell(sda_oe_n_o));
   cover property ($changed(tmr_v));
endmodule // charge_param_config_regs_asserts

bind charge_param_config_regs charge_param_config_regs_asserts chk_u
(
   .clk_i, .resetn_i, .scl_i, .sda_oe_n_o, .precharge_current_limit_o,
   .termination_current_limit_o, .charge_voltage_limit_o,
   .precharge_to_fast_threshold_o, .recharge_threshold_o, .termination_enable_o,
   .termination_indicator_select_o, .watchdog_period_select_o,
   .safety_timer_enable_o, .fast_charge_timer_select_o, .watchdog_restart_o
);
`default_nettype wire

// ===== test/serial_host_model.sv
// Behavioural two-wire host for the register link.
// Assumes the bench calls its tasks; SDA has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
#(
   parameter int HALF = 8 // Clocks per SCL high half; the low half is 4 more
)
(
   input wire logic clk_i,
   input wire logic sda_oe_n_i,
   input wire logic sda_dev_i,
   output logic scl_o,
   output logic sda_o
);
   logic scl_ff = 1'b1; // Idle bus high
   logic drv_ff = 1'b1; // Host side, 1 = released
   // Wired AND over the pull-up
   assign sda_o = drv_ff & (sda_oe_n_i | sda_dev_i);
   assign scl_o = scl_ff;
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // One bit: drive 4 clocks after a fall (hold time), sample mid high
   task automatic bit_io(input logic o, output logic s);
      hold(4);
      drv_ff <= o;
      hold(HALF);
      scl_ff <= 1'b1;
      hold(HALF / 2);
      s = sda_o;
      hold(HALF / 2);
      scl_ff <= 1'b0;
   endtask
   task automatic start_cond();
      hold(4);
      drv_ff <= 1'b1;
      hold(HALF);
      scl_ff <= 1'b1;
      hold(HALF);
      drv_ff <= 1'b0; // Fall while clock high
      hold(HALF);
      scl_ff <= 1'b0;
   endtask
   task automatic stop_cond();
      hold(4);
      drv_ff <= 1'b0;
      hold(HALF);
      scl_ff <= 1'b1;
      hold(HALF);
      drv_ff <= 1'b1; // Rise while clock high
      hold(HALF);
   endtask
   task automatic byte_out(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], b);
      bit_io(1'b1, b);
      ack = !b;
   endtask
   task automatic byte_in(input logic last, output logic [7:0] d);
      logic b;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(last, b); // No acknowledge ends a read
   endtask
endmodule // serial_host_model
`default_nettype wire

// ===== test/charge_param_config_regs_tb_top.sv
// Bench for the charger registers over the two-wire link.
// Assumes the host model and bound checker compile first.
`timescale 1ns/1ps
`default_nettype none
module charge_param_config_regs_tb_top;
   localparam logic [6:0] ADR = 7'h2A; // Arbitrary slave address
   localparam int LIMIT = 90000; // About twice the expected run
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   wire logic scl_i;
   wire logic sda_i;
   logic sda_o;
   logic sda_oe_n_o;
   logic [3:0] precharge_current_limit_o;
   logic [3:0] termination_current_limit_o;
   logic [5:0] charge_voltage_limit_o;
   logic precharge_to_fast_threshold_o;
   logic recharge_threshold_o;
   logic termination_enable_o;
   logic termination_indicator_select_o;
   logic [1:0] watchdog_period_select_o;
   logic safety_timer_enable_o;
   logic [1:0] fast_charge_timer_select_o;
   logic watchdog_restart_o;
   logic [7:0] shadow [256]; // Expected contents
   logic [7:0] corner [5] = '{8'hFF, 8'h00, 8'hE1, 8'h1E, 8'h24};
   logic [31:0] rnd = 32'h6C0C;
   int fail_count = 0;
   int n_checks = 0;
   int pulses = 0;
   int cyc = 0;
   wire logic [7:0] cur_v = {precharge_current_limit_o, termination_current_limit_o};
   wire logic [7:0] volt_v = {charge_voltage_limit_o, precharge_to_fast_threshold_o,
      recharge_threshold_o};
   wire logic [7:0] tmr_v = {termination_enable_o, termination_indicator_select_o,
      watchdog_period_select_o, safety_timer_enable_o, fast_charge_timer_select_o, 1'b0};
   charge_param_config_regs dut_u
   (
      .clk_i, .resetn_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o, .precharge_current_limit_o,
      .termination_current_limit_o, .charge_voltage_limit_o,
      .precharge_to_fast_threshold_o, .recharge_threshold_o, .termination_enable_o,
      .termination_indicator_select_o, .watchdog_period_select_o,
      .safety_timer_enable_o, .fast_charge_timer_select_o, .watchdog_restart_o
   );
   serial_host_model host_u
   (
      .clk_i, .sda_oe_n_i(sda_oe_n_o), .sda_dev_i(sda_o), .scl_o(scl_i), .sda_o(sda_i)
   );
   always #10 clk_i = ~clk_i;
   // Restart pulse counter and hang guard
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (watchdog_restart_o === 1'b1)
         pulses <= pulses + 1;
      if (cyc == LIMIT)
      begin
         fail_count++;
         end_sim();
      end
   end
   // ------------
   // Helpers
   // ------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic logic mapped(input logic [7:0] o);
      return o >= 8'h03 && o <= 8'h05;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic chk_ports();
      chk(cur_v, shadow[3]);
      chk(volt_v, shadow[4]);
      chk(tmr_v, shadow[5] & 8'hFE);
   endtask
   task automatic do_reset();
      resetn_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      foreach (shadow[i])
         shadow[i] = 8'h00;
      shadow[3] = 8'h11;
      shadow[4] = 8'hB2;
      shadow[5] = 8'h9A;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] o, input logic [7:0] d);
      logic ack;
      host_u.start_cond();
      host_u.byte_out({a, 1'b0}, ack);
      chk({7'h00, ack}, {7'h00, a == ADR});
      if (ack)
      begin
         host_u.byte_out(o, ack);
         host_u.byte_out(d, ack);
         if (mapped(o))
            shadow[o] = d;
      end
      host_u.stop_cond();
   endtask
   task automatic rd(input logic [7:0] o);
      logic ack;
      logic [7:0] d;
      logic [7:0] d2;
      host_u.start_cond();
      host_u.byte_out({ADR, 1'b0}, ack);
      host_u.byte_out(o, ack);
      host_u.start_cond(); // Repeated start keeps pointer
      host_u.byte_out({ADR, 1'b1}, ack);
      host_u.byte_in(1'b0, d); // Acknowledge asks for the next pointer
      host_u.byte_in(1'b1, d2);
      host_u.stop_cond();
      chk(d, shadow[o]);
      chk(d2, shadow[o + 8'h01]);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ------------
   // Main sequence
   // ------------
   initial
   begin
      logic [7:0] o;
      logic [7:0] d;
      do_reset();
      chk_ports();
      for (int i = 3; i <= 5; i++)
         rd(i[7:0]);
      $display("test defaults done");
      // Field boundaries, every code of each select except code 01 of timer bits 2:1
      for (int r = 3; r <= 5; r++)
         for (int k = 0; k < 5; k++)
         begin
            d = (r == 5) ? corner[k] & 8'hFE : corner[k];
            wr(ADR, r[7:0], d);
            chk_ports();
            rd(r[7:0]);
         end
      $display("test corners done");
      for (int n = 0; n < 10; n++)
      begin
         rnd = xs(rnd);
         o = 8'h03 + 8'(rnd[9:8] % 2'd3);
         d = rnd[7:0];
         if (o == 8'h05)
            d[0] = 1'b0;
         wr(ADR, o, d);
         chk_ports();
         rd(o);
      end
      $display("test random done");
      wr(ADR, 8'h07, 8'h5A);
      rd(8'h07);
      wr(ADR ^ 7'h01, 8'h04, 8'h00);
      chk_ports();
      $display("test refusals done");
      wr(ADR, 8'h01, 8'h40);
      chk(pulses[7:0], 8'h01);
      rd(8'h01);
      $display("test restart done");
      wr(ADR, 8'h03, 8'hA5);
      do_reset();
      chk_ports();
      rd(8'h03);
      $display("test second reset done");
      end_sim();
   end
endmodule // charge_param_config_regs_tb_top
`default_nettype wire
